// File: verif/grouped_interrupt_control_tb.sv
`timescale 1ns/1ps
module grouped_interrupt_control_tb;
   localparam logic [15:0] CTL0 = irq_ctl_pkg::ADDR_LEVEL_CTL_ZERO;
   localparam logic [15:0] CTL1 = irq_ctl_pkg::ADDR_LEVEL_CTL_ONE;
   localparam logic [15:0] CTL2 = irq_ctl_pkg::ADDR_EDGE_SELECT;
   localparam logic [15:0] CTL3 = irq_ctl_pkg::ADDR_TIMER_EXT_CTL;
   localparam logic [15:0] CTL4 = irq_ctl_pkg::ADDR_EXT_I2C_CTL;

   logic                        core_clk;
   logic                        reset_n;
   irq_ctl_pkg::pf_req_type     pf_req;
   logic [7:0]                  pf_rdata;
   logic [7:0]                  cpu_status;
   logic                        instr_boundary;
   logic [2:0]                  ext_pins;
   irq_ctl_pkg::periph_evt_type periph_evt;
   logic [4:0]                  level_request;
   int                          err_total;
   int                          n_compared;

   grouped_interrupt_control u_grouped_interrupt_control (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .pf_req         (pf_req),
      .pf_rdata       (pf_rdata),
      .cpu_status     (cpu_status),
      .instr_boundary (instr_boundary),
      .ext_pins       (ext_pins),
      .periph_evt     (periph_evt),
      .level_request  (level_request)
   );

   irq_source_model u_irq_source_model (
      .core_clk   (core_clk),
      .periph_evt (periph_evt),
      .ext_pins   (ext_pins)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      pf_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge core_clk);
      pf_req = '0;
   endtask : wr

   // Read data is registered, so it is looked at one cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      pf_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      pf_req = '0;
      check(pf_rdata, exp);
   endtask : rd_chk

   task automatic req_chk(input logic [4:0] exp);
      @(negedge core_clk);
      check({3'b000, level_request}, {3'b000, exp});
   endtask : req_chk

   task automatic t_reset_map;
      wr(16'h0105, 8'hFF);
      wr(16'h00FF, 8'hFF);
      wr(16'hFF01, 8'hFF);
      for (int i = 0; i < 5; i++) rd_chk(CTL0 + 16'(i), 8'h00);
      rd_chk(16'h0105, 8'h00);
      rd_chk(16'hFF01, 8'h00);
   endtask : t_reset_map

   task automatic t_timers;
      u_irq_source_model.fire(8'h70);
      rd_chk(CTL3, 8'h8A);
      rd_chk(CTL0, 8'h28);
      req_chk(5'h00);
      wr(CTL0, 8'h28);
      rd_chk(CTL0, 8'h28);
      wr(CTL3, 8'h00);
      rd_chk(CTL3, 8'h8A);
      wr(CTL3, 8'h02);
      rd_chk(CTL3, 8'h88);
      rd_chk(CTL0, 8'h28);
      wr(CTL3, 8'h08);
      rd_chk(CTL0, 8'h20);
      wr(CTL3, 8'h80);
      rd_chk(CTL0, 8'h00);
   endtask : t_timers

   task automatic t_display;
      u_irq_source_model.fire(8'h80);
      rd_chk(CTL1, 8'h02);
      wr(CTL1, 8'h00);
      rd_chk(CTL1, 8'h02);
      wr(CTL1, 8'hF3);
      rd_chk(CTL1, 8'h01);
      u_irq_source_model.fire(8'h80);
      req_chk(5'h08);
      wr(CTL1, 8'h02);
      rd_chk(CTL1, 8'h00);
   endtask : t_display

   task automatic t_i2c;
      u_irq_source_model.fire(8'h0C);
      rd_chk(CTL4, 8'h28);
      rd_chk(CTL1, 8'h08);
      wr(CTL4, 8'h28);
      rd_chk(CTL4, 8'h28);
      u_irq_source_model.fire(8'h02);
      rd_chk(CTL4, 8'h20);
      u_irq_source_model.fire(8'h01);
      rd_chk(CTL1, 8'h00);
      wr(CTL4, 8'h04);
      wr(CTL1, 8'h04);
      u_irq_source_model.fire(8'h08);
      req_chk(5'h10);
      wr(CTL1, 8'h00);
      req_chk(5'h00);
      u_irq_source_model.fire(8'h02);
      wr(CTL4, 8'h00);
   endtask : t_i2c

   task automatic t_pins;
      logic [15:0] pa[3];
      logic [7:0]  pv[3];
      pa = '{CTL0, CTL3, CTL4};
      pv = '{8'h02, 8'h20, 8'h02};
      for (int i = 0; i < 3; i++) begin
         u_irq_source_model.pin_drive(i, 1'b0);
         u_irq_source_model.pin_drive(i, 1'b1);
         rd_chk(pa[i], pv[i]);
         wr(pa[i], pv[i]);
         rd_chk(pa[i], 8'h00);
      end
      wr(CTL2, 8'hFF);
      rd_chk(CTL2, 8'h07);
      for (int i = 0; i < 3; i++) begin
         u_irq_source_model.pin_drive(i, 1'b0);
         rd_chk(pa[i], 8'h00);
         u_irq_source_model.pin_drive(i, 1'b1);
         rd_chk(pa[i], pv[i]);
         wr(pa[i], pv[i]);
      end
      wr(CTL2, 8'h00);
   endtask : t_pins

   task automatic t_priority;
      cpu_status = 8'hEF;
      wr(CTL3, 8'h01);
      wr(CTL0, 8'h05);
      u_irq_source_model.pin_drive(0, 1'b0);
      u_irq_source_model.fire(8'h40);
      req_chk(5'h00);
      cpu_status = 8'hFF;
      req_chk(5'h01);
      // Off a boundary the request must hold
      instr_boundary = 1'b0;
      wr(CTL0, 8'h07);
      req_chk(5'h01);
      instr_boundary = 1'b1;
      req_chk(5'h02);
      fork
         u_irq_source_model.fire(8'h40);
         wr(CTL3, 8'h03);
      join
      rd_chk(CTL3, 8'h03);
      instr_boundary = 1'b0;
      cpu_status = 8'hEF;
      req_chk(5'h00);
      cpu_status = 8'hFF;
      instr_boundary = 1'b1;
      wr(CTL0, 8'h01);
      req_chk(5'h00);
      wr(CTL3, 8'h40);
      wr(CTL0, 8'h10);
      u_irq_source_model.fire(8'h10);
      req_chk(5'h04);
      wr(CTL3, 8'h82);
      wr(CTL0, 8'h00);
      u_irq_source_model.pin_drive(0, 1'b1);
   endtask : t_priority

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      err_total      = 0;
      n_compared     = 0;
      reset_n        = 1'b0;
      pf_req         = '0;
      cpu_status     = 8'h00;
      instr_boundary = 1'b0;
      repeat (5) @(negedge core_clk);
      reset_n        = 1'b1;
      cpu_status     = 8'h10;
      instr_boundary = 1'b1;
      t_reset_map();
      t_timers();
      t_display();
      t_i2c();
      t_pins();
      t_priority();
      finish_test();
   end
endmodule : grouped_interrupt_control_tb

// File: verif/irq_source_model.sv
`timescale 1ns/1ps
module irq_source_model (
   // Clock
   input  wire logic                   core_clk,
   // Sources
   output irq_ctl_pkg::periph_evt_type periph_evt,
   output logic [2:0]                  ext_pins
);
   // Three cycles past the minimum of three, so a late sync edge still sees the level
   localparam int HOLD_CLKS = 6;

   initial begin
      periph_evt = '0;
      ext_pins   = 3'b111;
   end

   // Single-cycle event pulses, launched off the falling edge
   task automatic fire(input logic [7:0] e);
      @(negedge core_clk);
      periph_evt = irq_ctl_pkg::periph_evt_type'(e);
      @(negedge core_clk);
      periph_evt = '0;
   endtask : fire

   // Pin level held long enough to be caught
   task automatic pin_drive(input int idx, input logic lvl);
      @(negedge core_clk);
      ext_pins[idx] = lvl;
      repeat (HOLD_CLKS) @(negedge core_clk);
   endtask : pin_drive
endmodule : irq_source_model

// File: verilog/grouped_interrupt_control.sv
`timescale 1ns/1ps
module grouped_interrupt_control (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        reset_n,
   // Peripheral-file access
   input  wire irq_ctl_pkg::pf_req_type     pf_req,
   output logic [7:0]                       pf_rdata,
   // CPU status and boundary
   input  wire logic [7:0]                  cpu_status,
   input  wire logic                        instr_boundary,
   // Sources
   input  wire logic [2:0]                  ext_pins,
   input  wire irq_ctl_pkg::periph_evt_type periph_evt,
   // Requests to the CPU, one-hot by level one..five
   output logic [4:0]                       level_request
);

   logic [7:0] ctl0_reg, ctl0_next;
   logic [7:0] ctl1_reg, ctl1_next;
   logic [7:0] edge_reg, edge_next;
   logic [7:0] ctl3_reg, ctl3_next;
   logic [7:0] ctl4_reg, ctl4_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [4:0] req_reg, req_next;
   logic [2:0] pin_evt;
   logic [2:0] edge_sel;
   logic [4:0] level_flag;
   logic [4:0] level_en;
   logic       gie;

   // Write-one clear decode, used for every flag except the I2C and grouped flags
   function automatic logic wclr(input irq_ctl_pkg::pf_req_type r,
                                 input logic [15:0] a, input int b);
      wclr = r.wr && (r.addr == a) && r.wdata[b];
   endfunction : wclr

   // Sticky flag: set wins over clear
   function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
      flag_upd = set | (cur & ~clr);
   endfunction : flag_upd

   assign edge_sel[irq_ctl_pkg::PIN_ONE]   = edge_reg[irq_ctl_pkg::BIT_EDGE_ONE];
   assign edge_sel[irq_ctl_pkg::PIN_THREE] = edge_reg[irq_ctl_pkg::BIT_EDGE_THREE];
   assign edge_sel[irq_ctl_pkg::PIN_FIVE]  = edge_reg[irq_ctl_pkg::BIT_EDGE_FIVE];

   // Each pin is synchronised before edge detection
   genvar gi;
   generate
      for (gi = 0; gi < irq_ctl_pkg::NUM_PINS; gi++) begin : g_pin
         pin_edge_detect u_edge (
            .core_clk  (core_clk),
            .reset_n   (reset_n),
            .pin_async (ext_pins[gi]),
            .rising_sel(edge_sel[gi]),
            .edge_pulse(pin_evt[gi])
         );
      end
   endgenerate

   always_comb begin
      logic we0, we1, we2, we3, we4;
      we0 = pf_req.wr && (pf_req.addr == irq_ctl_pkg::ADDR_LEVEL_CTL_ZERO);
      we1 = pf_req.wr && (pf_req.addr == irq_ctl_pkg::ADDR_LEVEL_CTL_ONE);
      we2 = pf_req.wr && (pf_req.addr == irq_ctl_pkg::ADDR_EDGE_SELECT);
      we3 = pf_req.wr && (pf_req.addr == irq_ctl_pkg::ADDR_TIMER_EXT_CTL);
      we4 = pf_req.wr && (pf_req.addr == irq_ctl_pkg::ADDR_EXT_I2C_CTL);
      ctl0_next = ctl0_reg;
      ctl1_next = ctl1_reg;
      edge_next = edge_reg;
      ctl3_next = ctl3_reg;
      ctl4_next = ctl4_reg;
      // Enables take written data
      if (we0) begin
         ctl0_next[irq_ctl_pkg::BIT_EN0] = pf_req.wdata[irq_ctl_pkg::BIT_EN0];
         ctl0_next[irq_ctl_pkg::BIT_EN1] = pf_req.wdata[irq_ctl_pkg::BIT_EN1];
         ctl0_next[irq_ctl_pkg::BIT_EN2] = pf_req.wdata[irq_ctl_pkg::BIT_EN2];
      end
      if (we1) begin
         ctl1_next[irq_ctl_pkg::BIT_EN0] = pf_req.wdata[irq_ctl_pkg::BIT_EN0];
         ctl1_next[irq_ctl_pkg::BIT_EN1] = pf_req.wdata[irq_ctl_pkg::BIT_EN1];
      end
      if (we2) begin
         edge_next[irq_ctl_pkg::BIT_EDGE_THREE:0] =
            pf_req.wdata[irq_ctl_pkg::BIT_EDGE_THREE:0];
      end
      if (we3) begin
         ctl3_next[irq_ctl_pkg::BIT_EN0] = pf_req.wdata[irq_ctl_pkg::BIT_EN0];
         ctl3_next[irq_ctl_pkg::BIT_EN1] = pf_req.wdata[irq_ctl_pkg::BIT_EN1];
         ctl3_next[irq_ctl_pkg::BIT_EN2] = pf_req.wdata[irq_ctl_pkg::BIT_EN2];
         ctl3_next[irq_ctl_pkg::BIT_EN3] = pf_req.wdata[irq_ctl_pkg::BIT_EN3];
      end
      if (we4) begin
         ctl4_next[irq_ctl_pkg::BIT_EN0] = pf_req.wdata[irq_ctl_pkg::BIT_EN0];
         ctl4_next[irq_ctl_pkg::BIT_EN1] = pf_req.wdata[irq_ctl_pkg::BIT_EN1];
         ctl4_next[irq_ctl_pkg::BIT_EN2] = pf_req.wdata[irq_ctl_pkg::BIT_EN2];
      end
      // Sticky flags latch whatever the enables say
      ctl0_next[irq_ctl_pkg::BIT_FL0] = flag_upd(ctl0_reg[irq_ctl_pkg::BIT_FL0],
         pin_evt[irq_ctl_pkg::PIN_ONE],
         wclr(pf_req, irq_ctl_pkg::ADDR_LEVEL_CTL_ZERO, irq_ctl_pkg::BIT_FL0));
      ctl1_next[irq_ctl_pkg::BIT_FL0] = flag_upd(ctl1_reg[irq_ctl_pkg::BIT_FL0],
         periph_evt.display,
         wclr(pf_req, irq_ctl_pkg::ADDR_LEVEL_CTL_ONE, irq_ctl_pkg::BIT_FL0));
      ctl3_next[irq_ctl_pkg::BIT_FL0] = flag_upd(ctl3_reg[irq_ctl_pkg::BIT_FL0],
         periph_evt.timer_a,
         wclr(pf_req, irq_ctl_pkg::ADDR_TIMER_EXT_CTL, irq_ctl_pkg::BIT_FL0));
      ctl3_next[irq_ctl_pkg::BIT_FL1] = flag_upd(ctl3_reg[irq_ctl_pkg::BIT_FL1],
         periph_evt.timer_b,
         wclr(pf_req, irq_ctl_pkg::ADDR_TIMER_EXT_CTL, irq_ctl_pkg::BIT_FL1));
      ctl3_next[irq_ctl_pkg::BIT_FL2] = flag_upd(ctl3_reg[irq_ctl_pkg::BIT_FL2],
         pin_evt[irq_ctl_pkg::PIN_THREE],
         wclr(pf_req, irq_ctl_pkg::ADDR_TIMER_EXT_CTL, irq_ctl_pkg::BIT_FL2));
      ctl3_next[irq_ctl_pkg::BIT_FL3] = flag_upd(ctl3_reg[irq_ctl_pkg::BIT_FL3],
         periph_evt.timer_c,
         wclr(pf_req, irq_ctl_pkg::ADDR_TIMER_EXT_CTL, irq_ctl_pkg::BIT_FL3));
      ctl4_next[irq_ctl_pkg::BIT_FL0] = flag_upd(ctl4_reg[irq_ctl_pkg::BIT_FL0],
         pin_evt[irq_ctl_pkg::PIN_FIVE],
         wclr(pf_req, irq_ctl_pkg::ADDR_EXT_I2C_CTL, irq_ctl_pkg::BIT_FL0));
      // I2C flags ignore writes here; the I2C unit clears them
      ctl4_next[irq_ctl_pkg::BIT_FL1] = flag_upd(ctl4_reg[irq_ctl_pkg::BIT_FL1],
         periph_evt.i2c_master, periph_evt.i2c_master_clear);
      ctl4_next[irq_ctl_pkg::BIT_FL2] = flag_upd(ctl4_reg[irq_ctl_pkg::BIT_FL2],
         periph_evt.i2c_slave, periph_evt.i2c_slave_clear);
      // Grouped flags mirror their sub-flags, so they clear with them
      ctl0_next[irq_ctl_pkg::BIT_FL1] = ctl3_next[irq_ctl_pkg::BIT_FL0]
                                      | ctl3_next[irq_ctl_pkg::BIT_FL1];
      ctl0_next[irq_ctl_pkg::BIT_FL2] = ctl3_next[irq_ctl_pkg::BIT_FL2]
                                      | ctl3_next[irq_ctl_pkg::BIT_FL3];
      ctl1_next[irq_ctl_pkg::BIT_FL1] = ctl4_next[irq_ctl_pkg::BIT_FL0]
                                      | ctl4_next[irq_ctl_pkg::BIT_FL1]
                                      | ctl4_next[irq_ctl_pkg::BIT_FL2];
      // Unused bits stay zero
      ctl0_next[irq_ctl_pkg::BIT_FL3:irq_ctl_pkg::BIT_EN3] = 2'h0;
      ctl1_next[irq_ctl_pkg::BIT_FL3:irq_ctl_pkg::BIT_EN2] = 4'h0;
      edge_next[irq_ctl_pkg::BIT_FL3:irq_ctl_pkg::BIT_FL1] = 5'h00;
      ctl4_next[irq_ctl_pkg::BIT_FL3:irq_ctl_pkg::BIT_EN3] = 2'h0;
   end

   // Level view for requests; sub-enables qualify each sub-flag
   always_comb begin
      level_flag[0] = ctl0_reg[irq_ctl_pkg::BIT_FL0];
      level_flag[1] = (ctl3_reg[irq_ctl_pkg::BIT_FL0] & ctl3_reg[irq_ctl_pkg::BIT_EN0])
                    | (ctl3_reg[irq_ctl_pkg::BIT_FL1] & ctl3_reg[irq_ctl_pkg::BIT_EN1]);
      level_flag[2] = (ctl3_reg[irq_ctl_pkg::BIT_FL2] & ctl3_reg[irq_ctl_pkg::BIT_EN2])
                    | (ctl3_reg[irq_ctl_pkg::BIT_FL3] & ctl3_reg[irq_ctl_pkg::BIT_EN3]);
      level_flag[3] = ctl1_reg[irq_ctl_pkg::BIT_FL0];
      level_flag[4] = (ctl4_reg[irq_ctl_pkg::BIT_FL0] & ctl4_reg[irq_ctl_pkg::BIT_EN0])
                    | (ctl4_reg[irq_ctl_pkg::BIT_FL1] & ctl4_reg[irq_ctl_pkg::BIT_EN1])
                    | (ctl4_reg[irq_ctl_pkg::BIT_FL2] & ctl4_reg[irq_ctl_pkg::BIT_EN2]);
      level_en[0] = ctl0_reg[irq_ctl_pkg::BIT_EN0];
      level_en[1] = ctl0_reg[irq_ctl_pkg::BIT_EN1];
      level_en[2] = ctl0_reg[irq_ctl_pkg::BIT_EN2];
      level_en[3] = ctl1_reg[irq_ctl_pkg::BIT_EN0];
      level_en[4] = ctl1_reg[irq_ctl_pkg::BIT_EN1];
   end

   assign gie = cpu_status[irq_ctl_pkg::STATUS_GIE_BIT];

   // Lowest level number wins; request changes at a boundary, or clears off one when gie is low
   always_comb begin
      logic [4:0] pend;
      pend = level_flag & level_en & {irq_ctl_pkg::NUM_LEVELS{gie}};
      req_next = req_reg;
      if (instr_boundary) begin
         req_next = pend & (~pend + 5'h01);
      end else if (!gie) begin
         req_next = 5'h00;
      end
   end

   // Reads return live enables and flags
   always_comb begin
      rdata_next = 8'h00;
      if (pf_req.rd) begin
         unique case (pf_req.addr)
            irq_ctl_pkg::ADDR_LEVEL_CTL_ZERO: rdata_next = ctl0_reg;
            irq_ctl_pkg::ADDR_LEVEL_CTL_ONE:  rdata_next = ctl1_reg;
            irq_ctl_pkg::ADDR_EDGE_SELECT:    rdata_next = edge_reg;
            irq_ctl_pkg::ADDR_TIMER_EXT_CTL:  rdata_next = ctl3_reg;
            irq_ctl_pkg::ADDR_EXT_I2C_CTL:    rdata_next = ctl4_reg;
            default:                          rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0_reg  <= irq_ctl_pkg::REG_RESET;
         ctl1_reg  <= irq_ctl_pkg::REG_RESET;
         edge_reg  <= irq_ctl_pkg::REG_RESET;
         ctl3_reg  <= irq_ctl_pkg::REG_RESET;
         ctl4_reg  <= irq_ctl_pkg::REG_RESET;
         rdata_reg <= 8'h00;
         req_reg   <= 5'h00;
      end else begin
         ctl0_reg  <= ctl0_next;
         ctl1_reg  <= ctl1_next;
         edge_reg  <= edge_next;
         ctl3_reg  <= ctl3_next;
         ctl4_reg  <= ctl4_next;
         rdata_reg <= rdata_next;
         req_reg   <= req_next;
      end
   end

   assign pf_rdata      = rdata_reg;
   assign level_request = req_reg;

   property p_set_wins;
      @(posedge core_clk) disable iff (!reset_n)
      periph_evt.timer_a |=> ctl3_reg[irq_ctl_pkg::BIT_FL0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("timer a event lost");

   property p_clear_one;
      @(posedge core_clk) disable iff (!reset_n)
      (wclr(pf_req, irq_ctl_pkg::ADDR_LEVEL_CTL_ZERO, irq_ctl_pkg::BIT_FL0)
       && !pin_evt[irq_ctl_pkg::PIN_ONE]) |=> !ctl0_reg[irq_ctl_pkg::BIT_FL0];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("ext one flag not cleared");

   property p_zero_keeps;
      @(posedge core_clk) disable iff (!reset_n)
      (pf_req.wr && pf_req.addr == irq_ctl_pkg::ADDR_TIMER_EXT_CTL
       && !pf_req.wdata[irq_ctl_pkg::BIT_FL1] && ctl3_reg[irq_ctl_pkg::BIT_FL1])
      |=> ctl3_reg[irq_ctl_pkg::BIT_FL1];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

   property p_level_two;
      @(posedge core_clk) disable iff (!reset_n)
      (periph_evt.timer_a || periph_evt.timer_b) |=> ctl0_reg[irq_ctl_pkg::BIT_FL1];
   endproperty
   a_level_two: assert property (p_level_two) else $error("level two flag mismatch");

   property p_level_five;
      @(posedge core_clk) disable iff (!reset_n)
      periph_evt.i2c_slave |=> ctl1_reg[irq_ctl_pkg::BIT_FL1];
   endproperty
   a_level_five: assert property (p_level_five) else $error("level five not set");

   property p_i2c_no_wclr;
      @(posedge core_clk) disable iff (!reset_n)
      (ctl4_reg[irq_ctl_pkg::BIT_FL1] && !periph_evt.i2c_master_clear)
      |=> ctl4_reg[irq_ctl_pkg::BIT_FL1];
   endproperty
   a_i2c_no_wclr: assert property (p_i2c_no_wclr) else $error("i2c flag cleared");

   property p_gie_gate;
      @(posedge core_clk) disable iff (!reset_n)
      (instr_boundary && !gie) |=> (level_request == 5'h00);
   endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("request without gie");

   property p_onehot;
      @(posedge core_clk) disable iff (!reset_n)
      $onehot0(level_request);
   endproperty
   a_onehot: assert property (p_onehot) else $error("multiple levels requested");

   property p_zero_bits;
      @(posedge core_clk) disable iff (!reset_n)
      ctl0_reg[irq_ctl_pkg::BIT_FL3:irq_ctl_pkg::BIT_EN3] == 2'h0;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");

endmodule : grouped_interrupt_control

// File: verilog/irq_ctl_pkg.sv
package irq_ctl_pkg;

   // Peripheral-file addresses
   localparam logic [15:0] ADDR_LEVEL_CTL_ZERO  = 16'h0100;
   localparam logic [15:0] ADDR_LEVEL_CTL_ONE   = 16'h0101;
   localparam logic [15:0] ADDR_EDGE_SELECT     = 16'h0102;
   localparam logic [15:0] ADDR_TIMER_EXT_CTL   = 16'h0103;
   localparam logic [15:0] ADDR_EXT_I2C_CTL     = 16'h0104;

   // Bit positions shared by several registers
   localparam int BIT_EN0 = 0;
   localparam int BIT_FL0 = 1;
   localparam int BIT_EN1 = 2;
   localparam int BIT_FL1 = 3;
   localparam int BIT_EN2 = 4;
   localparam int BIT_FL2 = 5;
   localparam int BIT_EN3 = 6;
   localparam int BIT_FL3 = 7;
   localparam int BIT_EDGE_FIVE  = 0;
   localparam int BIT_EDGE_ONE   = 1;
   localparam int BIT_EDGE_THREE = 2;
   localparam int STATUS_GIE_BIT = 4;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int         NUM_PINS  = 3;
   localparam int         NUM_LEVELS = 5;

   // Pin index order within the pin vector
   localparam int PIN_ONE   = 0;
   localparam int PIN_THREE = 1;
   localparam int PIN_FIVE  = 2;

   // Peripheral-file access from the core
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pf_req_type;

   // Internal peripheral request pulses
   typedef struct packed {
      logic display;
      logic timer_a;
      logic timer_b;
      logic timer_c;
      logic i2c_master;
      logic i2c_slave;
      logic i2c_master_clear;
      logic i2c_slave_clear;
   } periph_evt_type;

endpackage : irq_ctl_pkg

// File: verilog/pin_edge_detect.sv
`timescale 1ns/1ps
module pin_edge_detect (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // Pin and selection
   input  wire logic pin_async,
   input  wire logic rising_sel,
   // Event
   output logic      edge_pulse
);

   logic       sync1_reg;
   logic       sync2_reg;
   logic       prev_reg;
   logic       pulse_next;
   logic       pulse_reg;
   logic [2:0] armed_reg;

   // Zero-cross pins have no debounce; noise here makes repeated events
   // Held off until prev holds a real sample, so reset makes no false edge
   always_comb begin
      pulse_next = armed_reg[2]
                 & (rising_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg));
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
         pulse_reg <= 1'b0;
         armed_reg <= 3'h0;
      end else begin
         armed_reg <= {armed_reg[1:0], 1'b1};
         sync1_reg <= pin_async;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         pulse_reg <= pulse_next;
      end
   end

   assign edge_pulse = pulse_reg;

endmodule : pin_edge_detect
